// file: core/low_power_mode_sequencer.sv
// low-power mode sequencer: standby and halt entry, flush, clock gating,
// oscillator restart, pll lock wait and timed resume.
// assumes wake pins and oscillator status are asynchronous inputs.
`timescale 1ns/1ps
module low_power_mode_sequencer #(
    parameter int unsigned PLL_LOCK_OSC_CYC = lpm_pkg::PLL_LOCK_OSC_DEF
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // entry request from the cpu
    input wire logic idle_req_i,
    input wire logic mode_halt_i,
    input wire logic input_clock_halve_bit_i,
    input wire logic crystal_source_i,
    // asynchronous wake sources and oscillator status
    input wire logic wake_i,
    input wire logic selected_wake_pin_i,
    input wire logic external_reset_pin_n_i,
    input wire logic osc_stable_i,
    // wake configuration
    input wire logic qualify_en_i,
    input wire logic [lpm_pkg::QUAL_W-1:0] standby_wake_qualify_count_i,
    input wire logic run_from_ram_i,
    input wire logic flash_sleep_i,
    input wire logic wake_int_en_i,
    // clock controls
    output logic external_clock_output_o,
    output logic sys_clk_en_o,
    output logic periph_clk_en_o,
    output logic pll_en_o,
    output logic watchdog_clk_en_o,
    output logic osc_en_o,
    // resume signalling
    output logic cpu_resume_o,
    output logic wake_irq_o,
    output logic in_low_power_o
);
    localparam int A_XLO = lpm_pkg::XCLK_LOW_MIN - 7;
    localparam int A_XHI = lpm_pkg::XCLK_LOW_MAX - 7;
    localparam logic [lpm_pkg::CNT_W-1:0] LOCK_LAST =
        lpm_pkg::CNT_W'(PLL_LOCK_OSC_CYC - 1);

    lpm_pkg::lpm_state_t st_q, st_d;
    logic [lpm_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [lpm_pkg::CNT_W-1:0] tgt_q, tgt_d;
    logic halt_q, halt_d;
    logic halve_q, halve_d;
    logic xtal_q, xtal_d;
    logic xoff_q, xoff_d;
    logic xclk_q, xclk_d;
    logic sys_q, sys_d;
    logic per_q, per_d;
    logic pll_q, pll_d;
    logic wdog_q, wdog_d;
    logic osc_q, osc_d;
    logic res_q, res_d;
    logic irq_q, irq_d;
    logic lp_q, lp_d;
    logic [3:0] s1_q, s2_q;
    logic gpio_prev_q;
    logic [3:0] div_q, div_d;
    logic tick_q, tick_d;
    logic gpio_fall;
    logic rst_low;
    logic [lpm_pkg::CNT_W-1:0] flush_last;
    logic [lpm_pkg::CNT_W-1:0] age_q;

    lpm_qual_if qif ();

    // resume delay for the wake path and memory in use
    function automatic logic [lpm_pkg::CNT_W-1:0] resume_cycles(
        input logic halt, input logic ram, input logic fsleep);
        if (!ram && fsleep) begin
            return lpm_pkg::FLASH_SLEEP_CYC;
        end else if (halt) begin
            return lpm_pkg::HALT_RAM_CYC;
        end
        return lpm_pkg::STBY_FAST_CYC;
    endfunction

    // worst-case latency allowed for the same choice
    function automatic logic [lpm_pkg::CNT_W-1:0] latency_max(
        input logic halt, input logic ram, input logic fsleep);
        if (!ram && fsleep) begin
            return lpm_pkg::FLASH_SLEEP_MAX;
        end else if (halt) begin
            return lpm_pkg::HALT_RAM_MAX;
        end
        return lpm_pkg::STBY_FAST_MAX;
    endfunction

    // two-flop synchronisers; the wake pin edge is taken from stage two
    // and a third flop so the metastable stage feeds nothing else
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s1_q <= lpm_pkg::SYNC_RST;
            s2_q <= lpm_pkg::SYNC_RST;
            gpio_prev_q <= 1'b1;
        end else begin
            s1_q <= {osc_stable_i, external_reset_pin_n_i,
                     selected_wake_pin_i, wake_i};
            s2_q <= s1_q;
            gpio_prev_q <= s2_q[lpm_pkg::SY_GPIO];
        end
    end

    assign gpio_fall = gpio_prev_q && !s2_q[lpm_pkg::SY_GPIO];
    assign rst_low = !s2_q[lpm_pkg::SY_RSTP];

    // oscillator cycle enable from a divider of the core clock
    always_comb begin
        tick_d = (div_q == 4'h0);
        div_d = (div_q == lpm_pkg::OSC_DIV - 4'h1) ? 4'h0 : div_q + 4'h1;
    end

    // divider registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            div_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // qualifier hookup; armed only in standby so flush ignores wakes
    assign qif.osc_tick = tick_q;
    assign qif.arm = (st_q == lpm_pkg::ST_STANDBY);
    assign qif.qual_en = qualify_en_i;
    assign qif.qual_count = standby_wake_qualify_count_i;
    assign qif.wake_lvl = s2_q[lpm_pkg::SY_WAKE];

    lpm_wake_qual u_qual (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .q(qif.qual)
    );

    // RULE2 flush length
    // halving the input clock doubles the time the pipe needs to drain
    assign flush_last = (halve_q ? lpm_pkg::FLUSH_CYC_HALVED
                                 : lpm_pkg::FLUSH_CYC_NORM) - 1'b1;

    // sequencer next state and next clock controls
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        tgt_d = tgt_q;
        halt_d = halt_q;
        halve_d = halve_q;
        xtal_d = xtal_q;
        xoff_d = xoff_q;
        sys_d = sys_q;
        per_d = per_q;
        pll_d = pll_q;
        wdog_d = wdog_q;
        osc_d = osc_q;
        res_d = 1'b0;
        irq_d = 1'b0;
        lp_d = lp_q;
        case (st_q)
            lpm_pkg::ST_RUN: begin
                if (idle_req_i) begin
                    st_d = lpm_pkg::ST_FLUSH;
                    cnt_d = '0;
                    halt_d = mode_halt_i;
                    halve_d = input_clock_halve_bit_i;
                    xtal_d = crystal_source_i;
                    lp_d = 1'b1;
                end
            end
            lpm_pkg::ST_FLUSH: begin
                // RULE16 flush ignores wakes
                // no wake source is looked at until entry is complete
                cnt_d = cnt_q + 1'b1;
                // RULE1 clock output low
                if (cnt_q == lpm_pkg::XCLK_OFF_AT) begin
                    xoff_d = 1'b1;
                end
                if (cnt_q == flush_last) begin
                    sys_d = 1'b0;
                    per_d = 1'b0;
                    cnt_d = '0;
                    if (halt_q) begin
                        // RULE7 halt shutdown
                        st_d = lpm_pkg::ST_HALT;
                        pll_d = 1'b0;
                        wdog_d = 1'b0;
                        osc_d = !xtal_q;
                    end else begin
                        // RULE3 standby keeps pll
                        st_d = lpm_pkg::ST_STANDBY;
                    end
                end
            end
            lpm_pkg::ST_STANDBY: begin
                // RULE4 standby resume delay
                if (qif.wake_ok) begin
                    st_d = lpm_pkg::ST_RESUME;
                    cnt_d = '0;
                    tgt_d = resume_cycles(1'b0, run_from_ram_i,
                                          flash_sleep_i) - 1'b1;
                    sys_d = 1'b1;
                    per_d = 1'b1;
                    xoff_d = 1'b0;
                end
            end
            lpm_pkg::ST_HALT: begin
                // RULE8 wake pin starts oscillator
                if (gpio_fall || rst_low) begin
                    st_d = lpm_pkg::ST_OSC;
                    osc_d = 1'b1;
                end
            end
            lpm_pkg::ST_OSC: begin
                // RULE9 pin held until stable
                // only the oscillator status moves us on, not the pin
                if (s2_q[lpm_pkg::SY_OSC]) begin
                    st_d = lpm_pkg::ST_LOCK;
                    cnt_d = '0;
                    pll_d = 1'b1;
                end
            end
            lpm_pkg::ST_LOCK: begin
                // RULE10 lock wait always
                if (tick_q) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == LOCK_LAST) begin
                        // RULE12 clocks back on
                        st_d = lpm_pkg::ST_RESUME;
                        cnt_d = '0;
                        // RULE11 halt resume delay
                        tgt_d = resume_cycles(1'b1, run_from_ram_i,
                                              flash_sleep_i) - 1'b1;
                        sys_d = 1'b1;
                        per_d = 1'b1;
                        wdog_d = 1'b1;
                        xoff_d = 1'b0;
                    end
                end
            end
            lpm_pkg::ST_RESUME: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == tgt_q) begin
                    // RULE5 resume strobe
                    st_d = lpm_pkg::ST_RUN;
                    res_d = 1'b1;
                    lp_d = 1'b0;
                    // RULE6 gated wake interrupt
                    irq_d = wake_int_en_i;
                end
            end
            default: begin
                st_d = lpm_pkg::ST_RUN;
                cnt_d = '0;
                sys_d = 1'b1;
                per_d = 1'b1;
                pll_d = 1'b1;
                wdog_d = 1'b1;
                osc_d = 1'b1;
                xoff_d = 1'b0;
                lp_d = 1'b0;
            end
        endcase
        // clock output runs at half the core rate while not gated
        xclk_d = xoff_d ? 1'b0 : !xclk_q;
    end

    // sequencer registers; everything runs after reset
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_q <= lpm_pkg::ST_RUN;
            cnt_q <= '0;
            tgt_q <= '0;
            halt_q <= 1'b0;
            halve_q <= 1'b0;
            xtal_q <= 1'b0;
            xoff_q <= 1'b0;
            xclk_q <= 1'b0;
            sys_q <= 1'b1;
            per_q <= 1'b1;
            pll_q <= 1'b1;
            wdog_q <= 1'b1;
            osc_q <= 1'b1;
            res_q <= 1'b0;
            irq_q <= 1'b0;
            lp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            tgt_q <= tgt_d;
            halt_q <= halt_d;
            halve_q <= halve_d;
            xtal_q <= xtal_d;
            xoff_q <= xoff_d;
            xclk_q <= xclk_d;
            sys_q <= sys_d;
            per_q <= per_d;
            pll_q <= pll_d;
            wdog_q <= wdog_d;
            osc_q <= osc_d;
            res_q <= res_d;
            irq_q <= irq_d;
            lp_q <= lp_d;
        end
    end

    assign external_clock_output_o = xclk_q;
    assign sys_clk_en_o = sys_q;
    assign periph_clk_en_o = per_q;
    assign pll_en_o = pll_q;
    assign watchdog_clk_en_o = wdog_q;
    assign osc_en_o = osc_q;
    assign cpu_resume_o = res_q;
    assign wake_irq_o = irq_q;
    assign in_low_power_o = lp_q;

    // cycles spent in resume, read only by the latency check
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || st_q != lpm_pkg::ST_RESUME) begin
            age_q <= '0;
        end else begin
            age_q <= age_q + 1'b1;
        end
    end

    a_xclk_low_window: assert property (@(posedge core_clk_i) // RULE1
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_RUN && idle_req_i) |->
        !xoff_q [*8] ##[A_XLO:A_XHI] (xoff_q && !xclk_q))
        else $error("clock output not low in its window");

    a_flush_norm_len: assert property (@(posedge core_clk_i) // RULE2
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_RUN && idle_req_i && !input_clock_halve_bit_i)
        |-> ##32 (sys_q ##1 !sys_q))
        else $error("short flush did not stop clock on time");

    a_flush_halved_len: assert property (@(posedge core_clk_i) // RULE2
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_RUN && idle_req_i && input_clock_halve_bit_i)
        |-> ##64 (sys_q ##1 !sys_q))
        else $error("halved flush did not stop clock on time");

    a_standby_gating: assert property (@(posedge core_clk_i) // RULE3
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_STANDBY) |->
        (pll_q && wdog_q && !per_q && !sys_q))
        else $error("standby gating wrong");

    a_halt_shutdown: assert property (@(posedge core_clk_i) // RULE7
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_HALT) |->
        (!pll_q && !per_q && !sys_q && osc_q == !xtal_q))
        else $error("halt shutdown wrong");

    a_flush_no_wake: assert property (@(posedge core_clk_i) // RULE16
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_FLUSH) |=> (st_q inside {lpm_pkg::ST_FLUSH,
        lpm_pkg::ST_STANDBY, lpm_pkg::ST_HALT}))
        else $error("flush left early");

    a_gpio_osc_start: assert property (@(posedge core_clk_i) // RULE8
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_HALT && gpio_fall) |=>
        (osc_q && st_q == lpm_pkg::ST_OSC))
        else $error("wake pin edge did not start oscillator");

    a_lock_hold: assert property (@(posedge core_clk_i) // RULE10
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_LOCK && !(tick_q && cnt_q == LOCK_LAST))
        |=> (st_q == lpm_pkg::ST_LOCK && !sys_q))
        else $error("lock wait cut short");

    a_halt_clocks_back: assert property (@(posedge core_clk_i) // RULE12
        disable iff (!rst_n_i)
        ($past(st_q) == lpm_pkg::ST_LOCK && st_q == lpm_pkg::ST_RESUME)
        |-> (sys_q && per_q && wdog_q && !xoff_q))
        else $error("clocks not re-enabled at halt exit");

    a_resume_latency: assert property (@(posedge core_clk_i) // RULE4 RULE11
        disable iff (!rst_n_i)
        (st_q == lpm_pkg::ST_RESUME) |->
        (age_q < latency_max(halt_q, run_from_ram_i, flash_sleep_i)))
        else $error("resume latency exceeded");

    a_resume_irq_gate: assert property (@(posedge core_clk_i) // RULE6
        disable iff (!rst_n_i)
        $rose(res_q) |-> (irq_q == $past(wake_int_en_i) && !lp_q))
        else $error("wake interrupt not gated by enable");
endmodule

// file: core/lpm_pkg.sv
// constants, types and state codes of the low-power mode sequencer
// assumes one 250 MHz core clock; oscillator cycles are divider ticks
// What this block does
// RULE1 - after idle entry, clock output goes low between 32 and 45 cycles
// RULE2 - system clock keeps running 32 cycles, or 64 when halving bit set
// RULE3 - standby gates peripheral clocks, keeps pll and watchdog running
// RULE4 - standby wake resumes within 100 or 1125 cycles after qualified wake
// RULE5 - latency ends at the resume strobe for the next instruction
// RULE6 - wake interrupt is raised at resume only when it is enabled
// RULE7 - halt stops peripherals and pll, oscillator too for crystal source
// RULE8 - falling edge on wake pin in halt starts the oscillator
// RULE9 - wake source holds wake pin low until oscillator is stable
// RULE10 - wait 131072 oscillator cycles after oscillator stable, always
// RULE11 - after lock, halt wake resumes within 1125 or 35 cycles
// RULE12 - halt wake ends by re-enabling core and peripheral clocks
// RULE13 - wake pin pulse lasts oscillator start-up plus 2 oscillator cycles
// RULE14 - reset pin wake pulse lasts start-up plus 8 oscillator cycles
// RULE15 - 6-bit qualify count demands wake width of two plus count
// RULE16 - wake events during entry flush are ignored until entry completes
package lpm_pkg;
    // counter widths
    localparam int unsigned CNT_W = 18;
    localparam int unsigned QUAL_W = 6;
    // entry flush lengths in system clock cycles
    localparam logic [CNT_W-1:0] FLUSH_CYC_NORM = 18'h00020;
    localparam logic [CNT_W-1:0] FLUSH_CYC_HALVED = 18'h00040;
    // clock output must be low inside this window after idle entry
    localparam int unsigned XCLK_LOW_MIN = 32;
    localparam int unsigned XCLK_LOW_MAX = 45;
    localparam logic [CNT_W-1:0] XCLK_OFF_AT = CNT_W'(XCLK_LOW_MIN - 2);
    // worst-case resume latencies in system clock cycles
    localparam logic [CNT_W-1:0] STBY_FAST_MAX = 18'h00064;
    localparam logic [CNT_W-1:0] FLASH_SLEEP_MAX = 18'h00465;
    localparam logic [CNT_W-1:0] HALT_RAM_MAX = 18'h00023;
    // resume delays actually used, each well inside its maximum
    localparam logic [CNT_W-1:0] STBY_FAST_CYC = 18'h00040;
    localparam logic [CNT_W-1:0] FLASH_SLEEP_CYC = 18'h00400;
    localparam logic [CNT_W-1:0] HALT_RAM_CYC = 18'h00018;
    // oscillator clock as an enable: core cycles per oscillator cycle
    localparam logic [3:0] OSC_DIV = 4'h4;
    // pll lock wait in oscillator cycles
    localparam int unsigned PLL_LOCK_OSC_DEF = 131072;
    // wake width demands in oscillator cycles
    localparam logic [QUAL_W:0] QUAL_BASE = 7'h02;
    localparam logic [QUAL_W:0] QUAL_NONE = 7'h03;
    // synchroniser lanes and their idle levels
    localparam int unsigned SY_WAKE = 0;
    localparam int unsigned SY_GPIO = 1;
    localparam int unsigned SY_RSTP = 2;
    localparam int unsigned SY_OSC = 3;
    localparam logic [3:0] SYNC_RST = 4'h6;
    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_RUN = 7'h01,
        ST_FLUSH = 7'h02,
        ST_STANDBY = 7'h04,
        ST_HALT = 7'h08,
        ST_OSC = 7'h10,
        ST_LOCK = 7'h20,
        ST_RESUME = 7'h40
    } lpm_state_t;
endpackage

// file: core/lpm_qual_if.sv
// bundle between the sequencer and its standby wake qualifier
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface lpm_qual_if;
    logic osc_tick;
    logic arm;
    logic qual_en;
    logic [lpm_pkg::QUAL_W-1:0] qual_count;
    logic wake_lvl;
    logic wake_ok;
    modport seq (
        output osc_tick,
        output arm,
        output qual_en,
        output qual_count,
        output wake_lvl,
        input wake_ok
    );
    modport qual (
        input osc_tick,
        input arm,
        input qual_en,
        input qual_count,
        input wake_lvl,
        output wake_ok
    );
endinterface

// file: core/lpm_wake_qual.sv
// standby wake qualifier: wake level must hold for a number of
// oscillator cycles before it counts; assumes a synchronised level
`timescale 1ns/1ps
module lpm_wake_qual (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // sequencer side
    lpm_qual_if.qual q
);
    logic [lpm_pkg::QUAL_W:0] run_q, run_d;
    logic ok_q, ok_d;
    logic [lpm_pkg::QUAL_W:0] need;

    // RULE15 width demand
    // demand is two plus the count, or three ticks with no qualification
    always_comb begin
        need = q.qual_en ? (lpm_pkg::QUAL_BASE +
                            (lpm_pkg::QUAL_W+1)'(q.qual_count))
                         : lpm_pkg::QUAL_NONE;
        run_d = run_q;
        ok_d = ok_q;
        if (!q.arm || !q.wake_lvl) begin
            run_d = '0;
            ok_d = 1'b0;
        end else if (q.osc_tick && !ok_q) begin
            run_d = run_q + 1'b1;
            ok_d = (run_d >= need);
        end
    end

    // registers; a glitch shorter than the demand restarts the run
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            run_q <= '0;
            ok_q <= 1'b0;
        end else begin
            run_q <= run_d;
            ok_q <= ok_d;
        end
    end

    assign q.wake_ok = ok_q;

    // qualified wake only stands while armed and held
    a_qual_held: assert property (@(posedge core_clk_i) // RULE15
        disable iff (!rst_n_i)
        ok_q |-> $past(q.wake_lvl) && $past(q.arm) && run_q >= need)
        else $error("wake qualified without enough held level");
endmodule

// file: tb/lpm_wake_partner.sv
// model of the wake sources and the crystal oscillator
// assumes the sequencer's oscillator enable is its only control
`timescale 1ns/1ps
module lpm_wake_partner #(
    parameter int STARTUP = 12
) (
    // clock and control
    input wire logic core_clk_i,
    input wire logic osc_en_i,
    input wire logic glitch_i,
    // wake lines and oscillator status
    output logic wake_o,
    output logic wake_pin_o,
    output logic rst_pin_n_o,
    output logic osc_stable_o
);
    logic wake_q = 1'b0;
    logic pin_q = 1'b1;
    logic rst_q = 1'b1;
    logic stab_q = 1'b1;
    int st_cnt = 0;
    // a glitch is noise on the wake line and the wake pin at once; the reset pin is untouched
    assign wake_o = wake_q | glitch_i;
    assign wake_pin_o = pin_q & ~glitch_i;
    assign rst_pin_n_o = rst_q;
    // oscillator settles a while after enable, drops at once when off
    assign osc_stable_o = stab_q;
    always @(posedge core_clk_i) begin
        if (!osc_en_i) begin
            st_cnt <= 0;
            stab_q <= 1'b0;
        end else if (st_cnt < STARTUP) begin
            st_cnt <= st_cnt + 1;
        end else begin
            stab_q <= 1'b1;
        end
    end
    // standby wake level held for len core cycles
    task automatic stby_pulse(input int len);
        @(negedge core_clk_i);
        wake_q = 1'b1;
        repeat (len) @(negedge core_clk_i);
        wake_q = 1'b0;
    endtask
    // halt wake through the pin or the reset pin
    task automatic halt_wake(input logic use_rst);
        int n;
        @(negedge core_clk_i);
        rst_q = ~use_rst;
        pin_q = use_rst;
        for (n = 0; n < 200 && !osc_stable_o; n++) @(negedge core_clk_i);
        repeat (use_rst ? 32 : 8) @(negedge core_clk_i);
        rst_q = 1'b1;
        pin_q = 1'b1;
    endtask
endmodule

// file: tb/testbench.sv
// self-checking bench of the low-power mode sequencer
// assumes a short pll lock count so halt wake-ups stay brief
`timescale 1ns/1ps
module testbench;
    localparam int LOCK = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic idle = 1'b0, halt = 1'b0, halve = 1'b0, xtal = 1'b0;
    logic qen = 1'b0, ram = 1'b0, fsleep = 1'b0, irq_en = 1'b0;
    logic glitch = 1'b0;
    logic [5:0] qcnt = 6'h00;
    wire wake, pin, rstp, ostab, xclk, sys_en, per_en, pll_en;
    wire wd_en, osc_en, resume, irq, inlp;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] seed;
    int i;
    // 250 MHz core clock
    initial forever #2 clk = ~clk;
    low_power_mode_sequencer #(.PLL_LOCK_OSC_CYC(LOCK))
        low_power_mode_sequencer_inst (
        .core_clk_i(clk), .rst_n_i(rst_n), .idle_req_i(idle),
        .mode_halt_i(halt), .input_clock_halve_bit_i(halve),
        .crystal_source_i(xtal), .wake_i(wake),
        .selected_wake_pin_i(pin), .external_reset_pin_n_i(rstp),
        .osc_stable_i(ostab), .qualify_en_i(qen),
        .standby_wake_qualify_count_i(qcnt), .run_from_ram_i(ram),
        .flash_sleep_i(fsleep), .wake_int_en_i(irq_en),
        .external_clock_output_o(xclk), .sys_clk_en_o(sys_en),
        .periph_clk_en_o(per_en), .pll_en_o(pll_en),
        .watchdog_clk_en_o(wd_en), .osc_en_o(osc_en),
        .cpu_resume_o(resume), .wake_irq_o(irq), .in_low_power_o(inlp));
    lpm_wake_partner lpm_wake_partner_inst (
        .core_clk_i(clk), .osc_en_i(osc_en), .glitch_i(glitch),
        .wake_o(wake), .wake_pin_o(pin), .rst_pin_n_o(rstp),
        .osc_stable_o(ostab));
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp,
                             input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic check_range(input int n, input int lo, input int hi,
                               input string what);
        n_checks++;
        if (n < lo || n > hi) begin
            failures++;
            $display("CHECK FAILED at %0t: %s took %0d", $time, what, n);
        end
    endtask
    // bounded wait for an output; -1 when the bound runs out
    task automatic wait_sig(input int which, input int lim, output int n);
        logic s;
        for (n = 0; n <= lim; n++) begin
            @(negedge clk);
            case (which)
                0: s = sys_en;
                1: s = osc_en;
                2: s = pll_en;
                default: s = resume;
            endcase
            if (s === 1'b1) return;
        end
        n = -1;
    endtask
    // resume bound depends on where the code runs from
    function automatic int resume_lim(input int fast);
        return (!ram && fsleep) ? 1125 : fast;
    endfunction
    task automatic stby_wake;
        int need, n;
        need = qen ? 2 + qcnt : 3;
        lpm_wake_partner_inst.stby_pulse(4 * need - 5);
        wait_sig(0, 4 * need + 12, n);
        check_range(n, -1, -1, "short wake");
        fork
            lpm_wake_partner_inst.stby_pulse(4 * need + 16);
            begin
                wait_sig(0, 4 * need + 40, n);
                check_range(n, 4 * need - 4, 4 * need + 40, "qual");
                wait_sig(3, resume_lim(100), n);
                check_range(n, 1, resume_lim(100), "resume");
                check_bit(irq, irq_en, "wake irq");
                check_bit(inlp, 1'b0, "low power exit");
            end
        join
    endtask
    task automatic halt_wake(input logic src);
        int n;
        fork
            lpm_wake_partner_inst.halt_wake(src);
            begin
                wait_sig(1, 20, n);
                check_range(n, 0, 20, "osc restart");
                wait_sig(2, 60, n);
                check_range(n, 0, 60, "pll restart");
                wait_sig(0, 4 * LOCK + 20, n);
                check_range(n, 4 * LOCK - 4, 4 * LOCK + 20, "lock");
                check_bit(per_en, 1'b1, "periph back");
                check_bit(wd_en, 1'b1, "watchdog back");
                wait_sig(3, resume_lim(35), n);
                check_range(n, 1, resume_lim(35), "halt resume");
                check_bit(irq, irq_en, "wake irq");
                check_bit(inlp, 1'b0, "low power exit");
            end
        join
    endtask
    // one entry with noise during flush, then a wake-up
    task automatic run_case(input logic h, input logic hv, input logic x,
                            input logic src);
        int k, fl;
        logic [31:0] v;
        v = $random(seed);
        @(negedge clk);
        {qcnt, qen, irq_en, fsleep, ram} = v[9:0];
        {halt, halve, xtal, idle} = {h, hv, x, 1'b1};
        @(negedge clk);
        idle = 1'b0;
        fl = hv ? 64 : 32;
        for (k = 1; k <= fl + 20; k++) begin
            glitch = (k >= 3 && k < 12);
            @(negedge clk);
            check_bit(sys_en, k < fl, "sys clock");
            check_bit(per_en, k < fl, "periph clock");
            check_bit(inlp, 1'b1, "low power flag");
            if (k >= 32) check_bit(xclk, 1'b0, "clock out");
            if (k >= fl) begin
                check_bit(pll_en, ~h, "pll");
                check_bit(wd_en, ~h, "watchdog");
                check_bit(osc_en, ~(h & x), "osc");
            end
        end
        glitch = 1'b0;
        if (!h) stby_wake();
        else halt_wake(src);
    endtask
    initial begin
        seed = 32'h3cfd;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        run_case(1'b0, 1'b0, 1'b1, 1'b0);
        run_case(1'b1, 1'b1, 1'b1, 1'b0);
        run_case(1'b1, 1'b0, 1'b0, 1'b1);
        for (i = 0; i < 8; i++) begin
            run_case(1'($random(seed)), 1'($random(seed)),
                     1'($random(seed)), 1'($random(seed)));
        end
        tally_and_finish();
    end
    // guard against a hang
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule
